// file: shared/cond_eval_pkg.sv
// package: constants for the condition evaluation block
package cond_eval_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] off_status_word = 8'h00;
  localparam logic [7:0] off_cond_select = 8'h04;
  localparam logic [7:0] off_flag_dir = 8'h08;
  localparam logic [7:0] off_flag_out = 8'h0c;
  localparam logic [7:0] off_flag_state = 8'h10;
  localparam logic [7:0] off_irq_status = 8'h14;
  localparam logic [7:0] off_irq_enable = 8'h18;
  localparam logic [7:0] off_irq_clear = 8'h1c;
  localparam logic [7:0] off_result = 8'h20;
  // ---------------------------------------------------------------
  // status word bit positions
  // ---------------------------------------------------------------
  localparam int bit_az = 0;
  localparam int bit_an = 1;
  localparam int bit_av = 2;
  localparam int bit_ac = 3;
  localparam int bit_as = 4;
  localparam int bit_mv = 5;
  localparam int bit_sv = 6;
  localparam int status_w = 7;
  // ---------------------------------------------------------------
  // direct condition codes (4 bit field of the instruction)
  // ---------------------------------------------------------------
  localparam logic [3:0] cc_eq = 4'h0;
  localparam logic [3:0] cc_ne = 4'h1;
  localparam logic [3:0] cc_gt = 4'h2;
  localparam logic [3:0] cc_le = 4'h3;
  localparam logic [3:0] cc_lt = 4'h4;
  localparam logic [3:0] cc_ge = 4'h5;
  localparam logic [3:0] cc_av = 4'h6;
  localparam logic [3:0] cc_nav = 4'h7;
  localparam logic [3:0] cc_ac = 4'h8;
  localparam logic [3:0] cc_nac = 4'h9;
  localparam logic [3:0] cc_swc = 4'ha;
  localparam logic [3:0] cc_nswc = 4'hb;
  localparam logic [3:0] cc_mv = 4'hc;
  localparam logic [3:0] cc_nmv = 4'hd;
  localparam logic [3:0] cc_ce = 4'he;
  localparam logic [3:0] cc_true = 4'hf;
  // ---------------------------------------------------------------
  // condition select values
  // ---------------------------------------------------------------
  localparam logic [7:0] sel_sign_set = 8'h00;
  localparam logic [7:0] sel_sign_clr = 8'h01;
  localparam logic [7:0] sel_flag_base = 8'h10;
  localparam logic [7:0] sel_shift_ovf = 8'h09;
  localparam logic [7:0] cond_select_rst = 8'h00;
  // ---------------------------------------------------------------
  // instruction kinds and offset widths
  // ---------------------------------------------------------------
  localparam logic [2:0] kind_compute = 3'h0;
  localparam logic [2:0] kind_rel_cjump = 3'h1;
  localparam logic [2:0] kind_rel_ujump = 3'h2;
  localparam logic [2:0] kind_long_jump = 3'h3;
  localparam logic [2:0] kind_loop_end = 3'h4;
  localparam int cjump_off_w = 13;
  localparam int ujump_off_w = 16;
  localparam int long_tgt_w = 24;
  localparam int acc_w = 40;
  localparam int top_used_w = 8;
  // ---------------------------------------------------------------
  // operand sources
  // ---------------------------------------------------------------
  localparam logic [2:0] src_alu_x_input = 3'h0;
  localparam logic [2:0] src_alu_y_input = 3'h1;
  localparam logic [2:0] src_mult_x_input = 3'h2;
  localparam logic [2:0] src_mult_y_input = 3'h3;
  localparam logic [2:0] src_shift_input = 3'h4;
  localparam logic [2:0] src_shift_result_acc = 3'h5;
  localparam logic [2:0] src_other = 3'h6;
  // irq bits: 0 taken branch, 1 shifter overflow set, 2 operand refused
  localparam int irq_w = 3;
endpackage

// file: core/cond_eval.sv
// condition evaluation for conditional instructions, branches and loops
`timescale 1ns/1ps
// Behaviour
// - status word effect visible one cycle later
// - shifter overflow flag tracks 40-bit overflow
// - accumulator three parts, top uses low 8
// - no direct condition code for shifter overflow
// - select 0x09 picks shifter overflow
// - select write effective one cycle later
// - soft condition offered true and inverted
// - equal condition uses alu zero flag
// - direct compare, overflow, carry, mult conditions
// - sign testable only via condition select
// - flag pins tested only via soft condition
// - sixteen flag pins, each direction configurable
// - flag state readable and soft testable
// - relative jumps carry 13 or 16-bit offsets
// - long jumps 24-bit, conditional, non-delayed
// - loop end only counter expired or forever
// - conditional operands only dedicated input registers
// - shift accumulator usable as multiply destination
module cond_eval
  import cond_eval_pkg::*;
#(
  parameter int flag_n = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // datapath status updates
  input wire logic status_we,
  input wire logic [status_w-1:0] status_new,
  input wire logic [acc_w-1:0] shift_wide_result,
  input wire logic shift_we,
  input wire logic counter_expired,
  // instruction issue from sequencer
  input wire logic instr_valid,
  input wire logic [2:0] instr_kind,
  input wire logic [3:0] instr_cond,
  input wire logic instr_delayed,
  input wire logic instr_multi,
  input wire logic [2:0] instr_src,
  input wire logic [23:0] instr_target,
  // flag pins
  input wire logic [flag_n-1:0] flag_in,
  output logic [flag_n-1:0] flag_out,
  output logic [flag_n-1:0] flag_oe_n,
  // results
  output logic cond_true,
  output logic commit,
  output logic branch_taken,
  output logic branch_delayed,
  output logic [23:0] branch_offset,
  output logic loop_exit,
  output logic operand_refused,
  output logic [acc_w-1:0] shift_result_acc,
  output logic irq
);
  if (flag_n < 1 || flag_n > 16) begin : g_fn_chk
    $error("flag_n must be 1..16");
  end
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [status_w-1:0] arith_status_word;
  logic [7:0] condition_select;
  logic [flag_n-1:0] flag_dir;
  logic [flag_n-1:0] flag_meta;
  logic [flag_n-1:0] flag_sync;
  logic [irq_w-1:0] irq_status;
  logic [irq_w-1:0] irq_enable;
  logic aw_hold;
  logic w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  // ---------------------------------------------------------------
  // condition decode
  // ---------------------------------------------------------------
  wire logic az = arith_status_word[bit_az];
  wire logic an = arith_status_word[bit_an];
  wire logic av = arith_status_word[bit_av];
  wire logic ac = arith_status_word[bit_ac];
  wire logic as_f = arith_status_word[bit_as];
  wire logic mv = arith_status_word[bit_mv];
  wire logic sv = arith_status_word[bit_sv];
  wire logic [flag_n-1:0] flag_state =
    (flag_dir & flag_out) | (~flag_dir & flag_sync);
  wire logic [7:0] flag_idx = condition_select - sel_flag_base;
  wire logic flag_sel_hit = condition_select >= sel_flag_base &&
    flag_idx < 8'(flag_n);
  // sign, shifter overflow and flags live only here
  wire logic soft_test_condition =
    (condition_select == sel_sign_set) ? as_f :
    (condition_select == sel_sign_clr) ? !as_f :
    (condition_select == sel_shift_ovf) ? sv :
    flag_sel_hit ? flag_state[flag_idx[3:0]] : 1'b0;
  logic cond_hit;
  always_comb begin
    case (instr_cond)
      cc_eq: cond_hit = az;
      cc_ne: cond_hit = !az;
      cc_gt: cond_hit = !az && !an;
      cc_le: cond_hit = az || an;
      cc_lt: cond_hit = an;
      cc_ge: cond_hit = !an;
      cc_av: cond_hit = av;
      cc_nav: cond_hit = !av;
      cc_ac: cond_hit = ac;
      cc_nac: cond_hit = !ac;
      cc_swc: cond_hit = soft_test_condition;
      cc_nswc: cond_hit = !soft_test_condition;
      cc_mv: cond_hit = mv;
      cc_nmv: cond_hit = !mv;
      cc_ce: cond_hit = counter_expired;
      default: cond_hit = 1'b1;
    endcase
  end
  // loops accept only expired counter or forever
  wire logic loop_cond_ok = instr_cond == cc_ce || instr_cond == cc_true;
  wire logic is_loop = instr_kind == kind_loop_end;
  wire logic is_cond = instr_cond != cc_true;
  wire logic src_dedicated = instr_src <= src_shift_result_acc;
  wire logic refuse = instr_valid && (is_cond || instr_multi) &&
    !src_dedicated && instr_kind == kind_compute;
  wire logic eval_true = is_loop ? (loop_cond_ok && cond_hit) : cond_hit;
  wire logic is_jump = instr_kind == kind_rel_cjump ||
    instr_kind == kind_rel_ujump || instr_kind == kind_long_jump;
  wire logic take = instr_valid && is_jump && eval_true && !is_loop;
  // offset widths per branch kind, sign extended
  wire logic [23:0] off_c = {{(24-cjump_off_w){instr_target[12]}},
    instr_target[cjump_off_w-1:0]};
  wire logic [23:0] off_u = {{(24-ujump_off_w){instr_target[15]}},
    instr_target[ujump_off_w-1:0]};
  wire logic [23:0] next_offset =
    (instr_kind == kind_rel_cjump) ? off_c :
    (instr_kind == kind_rel_ujump) ? off_u : instr_target;
  // unconditional relative form is never taken unless the condition field is cc_true
  wire logic uj_cond_ok = instr_kind != kind_rel_ujump || !is_cond;
  wire logic next_delayed = instr_delayed &&
    instr_kind != kind_long_jump;
  // overflow: top two bits of the 40-bit result (39 and 38) differ
  wire logic next_sv = shift_wide_result[acc_w-1] !=
    shift_wide_result[acc_w-2];
  // ---------------------------------------------------------------
  // axi4-lite decode
  // ---------------------------------------------------------------
  wire logic wr_go = aw_hold && w_hold && !s_axi_bvalid;
  wire logic wr_cs = wr_go && aw_addr == off_cond_select;
  wire logic wr_dir = wr_go && aw_addr == off_flag_dir;
  wire logic wr_out = wr_go && aw_addr == off_flag_out;
  wire logic wr_en = wr_go && aw_addr == off_irq_enable;
  wire logic wr_clr = wr_go && aw_addr == off_irq_clear;
  wire logic wr_ok = aw_addr == off_cond_select ||
    aw_addr == off_flag_dir || aw_addr == off_flag_out ||
    aw_addr == off_irq_enable || aw_addr == off_irq_clear;
  wire logic rd_go = s_axi_arvalid && s_axi_arready;
  logic [31:0] rd_mux;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      off_status_word: rd_mux = 32'(arith_status_word);
      off_cond_select: rd_mux = 32'(condition_select);
      off_flag_dir: rd_mux = 32'(flag_dir);
      off_flag_out: rd_mux = 32'(flag_out);
      off_flag_state: rd_mux = 32'(flag_state);
      off_irq_status: rd_mux = 32'(irq_status);
      off_irq_enable: rd_mux = 32'(irq_enable);
      off_irq_clear: rd_mux = 32'h0;
      off_result: rd_mux = {30'h0, soft_test_condition, cond_true};
      default: begin
        rd_mux = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end
  wire logic [irq_w-1:0] irq_ev = {refuse, shift_we && next_sv,
    take && uj_cond_ok};
  wire logic [irq_w-1:0] next_irq_status =
    (irq_status & ~(wr_clr ? w_data[irq_w-1:0] : '0)) | irq_ev;
  // ---------------------------------------------------------------
  // axi channels
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      s_axi_awready <= !aw_hold && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_hold && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // ---------------------------------------------------------------
  // registers written by software; strobe lane 0 gates only the condition select write
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      condition_select <= cond_select_rst;
      flag_dir <= '0;
      flag_out <= '0;
      flag_oe_n <= '1;
      irq_enable <= '0;
    end else begin
      if (wr_cs && w_strb[0]) condition_select <= w_data[7:0];
      if (wr_dir) flag_dir <= w_data[flag_n-1:0];
      if (wr_out) flag_out <= w_data[flag_n-1:0];
      flag_oe_n <= wr_dir ? ~w_data[flag_n-1:0] : ~flag_dir;
      if (wr_en) irq_enable <= w_data[irq_w-1:0];
    end
  end
  // flag pins come from outside: two stages before use
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      flag_meta <= '0;
      flag_sync <= '0;
    end else begin
      flag_meta <= flag_in;
      flag_sync <= flag_meta;
    end
  end
  // ---------------------------------------------------------------
  // status word and shift accumulator
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      arith_status_word <= '0;
      shift_result_acc <= '0;
    end else begin
      // suppressed when the issuing instruction is false
      if (status_we && !(instr_valid && !eval_true)) begin
        arith_status_word <= status_new;
      end
      if (shift_we && !(instr_valid && !eval_true)) begin
        arith_status_word[bit_sv] <= next_sv;
        // all 40 bits, low byte of the top part included
        shift_result_acc <= shift_wide_result;
      end
    end
  end
  // ---------------------------------------------------------------
  // results toward the sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cond_true <= 1'b0;
      commit <= 1'b0;
      branch_taken <= 1'b0;
      branch_delayed <= 1'b0;
      branch_offset <= 24'h0;
      loop_exit <= 1'b0;
      operand_refused <= 1'b0;
      irq_status <= '0;
      irq <= 1'b0;
    end else begin
      cond_true <= instr_valid && eval_true;
      commit <= instr_valid && eval_true && !refuse;
      branch_taken <= take && uj_cond_ok;
      branch_delayed <= take && uj_cond_ok && next_delayed;
      branch_offset <= next_offset;
      loop_exit <= instr_valid && is_loop && loop_cond_ok &&
        cond_hit;
      operand_refused <= refuse;
      irq_status <= next_irq_status;
      irq <= |(next_irq_status & irq_enable);
    end
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_sel_write;
    wr_cs && w_strb[0] && w_data[7:0] == sel_shift_ovf;
  endsequence
  property p_sel_sv;
    @(posedge ref_clk) disable iff (!rst_n)
      s_sel_write ##1 (wr_cs == 1'b0) |-> soft_test_condition == sv;
  endproperty
  a_sel_sv: assert property (p_sel_sv) else $error("sel sv");
  property p_sel_late;
    @(posedge ref_clk) disable iff (!rst_n)
      wr_cs && w_strb[0] |=> condition_select == $past(w_data[7:0]);
  endproperty
  a_sel_late: assert property (p_sel_late) else $error("late");
  property p_eq;
    @(posedge ref_clk) disable iff (!rst_n)
      instr_valid && instr_cond == cc_eq && instr_kind == kind_compute
      |=> cond_true == $past(az);
  endproperty
  a_eq: assert property (p_eq) else $error("eq wrong");
  property p_swc_inv;
    @(posedge ref_clk) disable iff (!rst_n)
      instr_valid && instr_cond == cc_nswc && !is_loop
      |=> cond_true != $past(soft_test_condition);
  endproperty
  a_swc_inv: assert property (p_swc_inv) else $error("inv");
  property p_loop;
    @(posedge ref_clk) disable iff (!rst_n)
      instr_valid && is_loop && !loop_cond_ok |=> !loop_exit;
  endproperty
  a_loop: assert property (p_loop) else $error("loop end");
  property p_refuse;
    @(posedge ref_clk) disable iff (!rst_n)
      instr_valid && instr_multi && instr_src == src_other &&
      instr_kind == kind_compute |=> operand_refused && !commit;
  endproperty
  a_refuse: assert property (p_refuse) else $error("src");
  property p_long;
    @(posedge ref_clk) disable iff (!rst_n)
      instr_valid && instr_kind == kind_long_jump |=> !branch_delayed;
  endproperty
  a_long: assert property (p_long) else $error("long delay");
  property p_false_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      instr_valid && !eval_true |=> $stable(arith_status_word);
  endproperty
  a_false_hold: assert property (p_false_hold) else $error("upd");
  property p_status_lat;
    @(posedge ref_clk) disable iff (!rst_n)
      status_we && !shift_we && (!instr_valid || eval_true)
      |=> arith_status_word == $past(status_new);
  endproperty
  a_status_lat: assert property (p_status_lat) else $error("st");
endmodule // cond_eval

// file: dv/seq_model.sv
// sequencer and datapath model driving the issue side of the block
`timescale 1ns/1ps
module seq_model
  import cond_eval_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // instruction issue
  output logic instr_valid,
  output logic [2:0] instr_kind,
  output logic [3:0] instr_cond,
  output logic instr_delayed,
  output logic instr_multi,
  output logic [2:0] instr_src,
  output logic [23:0] instr_target,
  // datapath updates
  output logic status_we,
  output logic [status_w-1:0] status_new,
  output logic shift_we,
  output logic [acc_w-1:0] shift_wide_result
);
  initial begin
    {instr_valid, instr_kind, instr_cond, instr_delayed} = '0;
    {instr_multi, instr_src, instr_target, status_we} = '0;
    {status_new, shift_we, shift_wide_result} = '0;
  end
  // ------
  // one instruction, with an optional status load in the same cycle
  // ------
  task automatic exec(input logic [2:0] k, input logic [3:0] c,
      input logic d, input logic m, input logic [2:0] s,
      input logic [23:0] t, input logic we, input logic [6:0] st);
    @(posedge ref_clk);
    instr_valid <= 1'b1;
    instr_kind <= k;
    instr_cond <= c;
    instr_delayed <= d;
    instr_multi <= m;
    instr_src <= s;
    instr_target <= t;
    status_we <= we;
    status_new <= st;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    status_we <= 1'b0;
    // valid and status_we drop; cond, target and status fields show the inverse; kind, src, delayed and multi keep their value
    instr_cond <= ~c;
    instr_target <= ~t;
    status_new <= ~st;
  endtask
  task automatic shift(input logic [acc_w-1:0] v);
    @(posedge ref_clk);
    shift_we <= 1'b1;
    shift_wide_result <= v;
    @(posedge ref_clk);
    shift_we <= 1'b0;
    shift_wide_result <= ~v;
  endtask
endmodule // seq_model

// file: dv/tb_cond_eval.sv
// self-checking bench for the condition evaluation block
`timescale 1ns/1ps
module tb_cond_eval
  import cond_eval_pkg::*;
;
  logic ref_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, status_we, shift_we;
  logic counter_expired, instr_valid, instr_delayed, instr_multi, irq;
  logic cond_true, commit, branch_taken, branch_delayed, loop_exit;
  logic operand_refused;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, instr_cond;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [2:0] instr_kind, instr_src;
  logic [23:0] instr_target, branch_offset;
  logic [status_w-1:0] status_new;
  logic [acc_w-1:0] shift_wide_result, shift_result_acc;
  logic [15:0] flag_in, flag_out, flag_oe_n;
  int miscompares, samples_checked;
  logic [3:0] codes [13] = '{cc_eq, cc_ne, cc_av, cc_nav, cc_ac, cc_nac,
    cc_mv, cc_nmv, cc_gt, cc_le, cc_lt, cc_ge, cc_true};
  logic [6:0] stv [7] = '{7'h01, 7'h04, 7'h08, 7'h20, 7'h12, 7'h40, 7'h00};

  cond_eval #(.flag_n(16)) u_cond_eval (.ref_clk, .rst_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .status_we,
    .status_new, .shift_wide_result, .shift_we, .counter_expired,
    .instr_valid, .instr_kind, .instr_cond, .instr_delayed, .instr_multi,
    .instr_src, .instr_target, .flag_in, .flag_out, .flag_oe_n, .cond_true,
    .commit, .branch_taken, .branch_delayed, .branch_offset, .loop_exit,
    .operand_refused, .shift_result_acc, .irq);
  seq_model u_seq_model (.ref_clk, .instr_valid, .instr_kind, .instr_cond,
    .instr_delayed, .instr_multi, .instr_src, .instr_target, .status_we,
    .status_new, .shift_we, .shift_wide_result);

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // ------
  // checking and bus tasks
  // ------
  task automatic chk(input string n, input logic [39:0] s, e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic hang(input int n);
    if (n == 40) begin
      miscompares++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (n = 0; n < 40; n++) begin
      @(posedge ref_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    rs = s_axi_bresp;
    hang(n);
  endtask
  task automatic rdr(input logic [7:0] a);
    int n;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (n = 0; n < 40; n++) begin
      @(posedge ref_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    hang(n);
  endtask
  // ------
  // instruction helpers
  // ------
  task automatic ex(input logic [2:0] k, input logic [3:0] c, input logic d,
      m, input logic [2:0] s, input logic [23:0] t, input logic we,
      input logic [6:0] st);
    u_seq_model.exec(k, c, d, m, s, t, we, st);
    #1;
  endtask
  task automatic cx(input logic [3:0] c);
    ex(kind_compute, c, 1'b0, 1'b0, src_alu_x_input, 24'h0, 1'b0, 7'h00);
  endtask
  task automatic ld(input logic [6:0] st);
    ex(kind_compute, cc_true, 1'b0, 1'b0, src_alu_x_input, 24'h0, 1'b1, st);
  endtask
  task automatic br(input logic [2:0] k, input logic [3:0] c, input logic d,
      input logic [23:0] t, input logic et, ed, input logic [23:0] eo);
    ex(k, c, d, 1'b0, src_alu_x_input, t, 1'b0, 7'h00);
    chk("branch_taken", branch_taken, et);
    if (et) begin
      chk("branch_delayed", branch_delayed, ed);
      chk("branch_offset", branch_offset, eo);
    end
  endtask
  task automatic op(input logic m, input logic [2:0] s, input logic e);
    ex(kind_compute, cc_true, 1'b0, m, s, 24'h0, 1'b0, 7'h00);
    chk("operand_refused", operand_refused, e);
  endtask
  function automatic logic dexp(input logic [3:0] c, input logic [6:0] st);
    case (c)
      cc_eq: return st[bit_az];
      cc_ne: return !st[bit_az];
      cc_av: return st[bit_av];
      cc_nav: return !st[bit_av];
      cc_ac: return st[bit_ac];
      cc_nac: return !st[bit_ac];
      cc_mv: return st[bit_mv];
      cc_nmv: return !st[bit_mv];
      cc_gt: return !st[bit_az] && !st[bit_an];
      cc_le: return st[bit_az] || st[bit_an];
      cc_lt: return st[bit_an];
      cc_ge: return !st[bit_an];
      default: return 1'b1;
    endcase
  endfunction
  // ------
  // main sequence
  // ------
  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, counter_expired, flag_in} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    miscompares = 0;
    samples_checked = 0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    s_axi_wstrb <= 4'hf;
    chk("flag_oe_n", flag_oe_n, 16'hffff);
    rdr(off_cond_select);
    chk("cond_select", rd, cond_select_rst);
    rdr(8'h24);
    chk("rresp", {rs, rd}, {2'b10, 32'h0});
    wr(8'h24, 32'h0);
    chk("bresp", rs, 2'b10);
    $display("test reset done");
    foreach (stv[i]) begin
      ld(stv[i]);
      rdr(off_status_word);
      chk("status_word", rd, stv[i]);
      foreach (codes[j]) begin
        cx(codes[j]);
        chk("cond_true", cond_true, dexp(codes[j], stv[i]));
      end
    end
    ld(7'h01);
    ex(kind_compute, cc_eq, 1'b0, 1'b0, src_alu_x_input, 24'h0, 1'b1, 7'h00);
    chk("old_status", {commit, cond_true}, 2'b11);
    cx(cc_eq);
    chk("new_status", cond_true, 1'b0);
    ld(7'h01);
    ex(kind_compute, cc_ne, 1'b0, 1'b0, src_alu_x_input, 24'h0, 1'b1, 7'h08);
    chk("commit", commit, 1'b0);
    rdr(off_status_word);
    chk("suppressed", rd, 32'h01);
    $display("test conditions done");
    ld(7'h10);
    wr(off_irq_enable, 32'h0);
    wr(off_irq_clear, 32'h7);
    br(kind_rel_cjump, cc_true, 1'b1, 24'h001fff, 1'b1, 1'b1, 24'hffffff);
    br(kind_rel_cjump, cc_eq, 1'b0, 24'h000123, 1'b0, 1'b0, 24'h0);
    br(kind_rel_ujump, cc_true, 1'b1, 24'h008000, 1'b1, 1'b1, 24'hff8000);
    br(kind_long_jump, cc_ne, 1'b1, 24'habcdef, 1'b1, 1'b0, 24'habcdef);
    br(kind_long_jump, cc_eq, 1'b0, 24'h123456, 1'b0, 1'b0, 24'h0);
    chk("irq_masked", irq, 1'b0);
    rdr(off_irq_status);
    chk("irq_status", rd[0], 1'b1);
    wr(off_irq_enable, 32'h1);
    repeat (2) @(posedge ref_clk);
    #1 chk("irq", irq, 1'b1);
    wr(off_irq_clear, 32'h1);
    repeat (2) @(posedge ref_clk);
    #1 chk("irq_cleared", irq, 1'b0);
    $display("test branches done");
    wr(off_cond_select, sel_sign_set);
    cx(cc_swc);
    chk("sign_set", cond_true, 1'b1);
    cx(cc_nswc);
    chk("sign_set_inv", cond_true, 1'b0);
    wr(off_cond_select, sel_sign_clr);
    cx(cc_swc);
    chk("sign_clr", cond_true, 1'b0);
    u_seq_model.shift(40'h80_0000_0000);
    wr(off_cond_select, sel_shift_ovf);
    cx(cc_swc);
    chk("shift_ovf", cond_true, 1'b1);
    rdr(off_status_word);
    chk("ovf_bit", rd[bit_sv], 1'b1);
    u_seq_model.shift(40'h00_1234_5678);
    cx(cc_swc);
    chk("shift_ok", cond_true, 1'b0);
    chk("acc_low", shift_result_acc[31:0], 32'h12345678);
    $display("test soft condition done");
    flag_in <= 16'h0008;
    wr(off_flag_dir, 32'h0);
    wr(off_cond_select, sel_flag_base + 8'h03);
    cx(cc_swc);
    chk("flag_set", cond_true, 1'b1);
    rdr(off_flag_state);
    chk("flag_state", rd[15:0], 16'h0008);
    wr(off_cond_select, sel_flag_base + 8'h04);
    cx(cc_swc);
    chk("flag_clr", cond_true, 1'b0);
    wr(off_flag_dir, 32'hffff);
    wr(off_flag_out, 32'ha5a5);
    chk("flag_pins", {flag_oe_n, flag_out}, 32'h0000a5a5);
    $display("test flags done");
    counter_expired <= 1'b1;
    ex(kind_loop_end, cc_ce, 1'b0, 1'b0, src_alu_x_input, 24'h0, 1'b0, 7'h0);
    chk("loop_ce", loop_exit, 1'b1);
    ex(kind_loop_end, cc_ne, 1'b0, 1'b0, src_alu_x_input, 24'h0, 1'b0, 7'h0);
    chk("loop_arith", loop_exit, 1'b0);
    op(1'b1, src_other, 1'b1);
    op(1'b1, src_shift_result_acc, 1'b0);
    op(1'b0, src_other, 1'b0);
    $display("test loops and operands done");
    wrap_up();
  end
endmodule // tb_cond_eval
